// file: rtl/sepc_defines.svh
// Constants for the serial EEPROM program control block.
// Assumes inclusion by bare name from any design file.
`ifndef SEPC_DEFINES_SVH
`define SEPC_DEFINES_SVH

`define SEPC_OP_EXT        2'h0
`define SEPC_OP_WRITE      2'h1
`define SEPC_OP_READ       2'h2
`define SEPC_OP_ERASE      2'h3
`define SEPC_EXT_DISABLE   2'h0
`define SEPC_EXT_WRALL     2'h1
`define SEPC_EXT_ERALL     2'h2
`define SEPC_EXT_ENABLE    2'h3
`define SEPC_ADDR_W        10
`define SEPC_DATA_W        16
`define SEPC_CYCLE_NS      100
`define SEPC_PROG_TIME_NS  5000000
`define SEPC_PROG_CYCLES   (`SEPC_PROG_TIME_NS / `SEPC_CYCLE_NS)

`endif

// file: rtl/sepc_pkg.sv
// Types for the serial EEPROM program control block.
// Assumes sepc_defines.svh is compiled alongside.
package sepc_pkg;

	typedef enum logic [2:0] {
		SEPC_ST_IDLE,
		SEPC_ST_CMD,
		SEPC_ST_READ,
		SEPC_ST_WAIT
	} sepc_state_e;

	typedef enum logic [1:0] {
		SEPC_JOB_NONE,
		SEPC_JOB_ONE,
		SEPC_JOB_ALL
	} sepc_job_e;

endpackage

// file: rtl/sepc_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes one clock; output is stable in the ref_clk domain.
`timescale 1ns/10ps
`default_nettype none
module sepc_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta_r;
		logic [W-1:0] sync_r;
	} sepc_sync_s;

	sepc_sync_s st_r;
	sepc_sync_s st_nxt;

	always_comb begin
		st_nxt.meta_r = pin_in;
		st_nxt.sync_r = st_r.meta_r;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.sync_r;
endmodule
`default_nettype wire

// file: rtl/sepc_timer.sv
// Self-timed program cycle counter, runs on ref_clk only.
// Assumes start is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module sepc_timer #(
	parameter int CYCLES = 50000
) (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	typedef struct packed {
		logic [31:0] cnt_r;
		logic        busy_r;
		logic        done_r;
	} sepc_tmr_s;

	sepc_tmr_s st_r;
	sepc_tmr_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.done_r = 1'b0;
		if (start && !st_r.busy_r) begin
			st_nxt.busy_r = 1'b1;
			st_nxt.cnt_r  = 32'(CYCLES - 1);
		end else if (st_r.busy_r) begin
			if (st_r.cnt_r == 32'h0000_0000) begin
				st_nxt.busy_r = 1'b0;
				st_nxt.done_r = 1'b1;
			end else begin
				st_nxt.cnt_r = st_r.cnt_r - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.busy_r;
	assign done = st_r.done_r;
endmodule
`default_nettype wire

// file: rtl/sepc_top.sv
// Serial EEPROM program and erase control, x16 organisation.
// Assumes pins arrive asynchronously and pass through sepc_sync.
`timescale 1ns/10ps
`default_nettype none
`include "sepc_defines.svh"
module sepc_top #(
	parameter int AW         = `SEPC_ADDR_W,
	parameter int DW         = `SEPC_DATA_W,
	parameter int PROG_CYCLES = `SEPC_PROG_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic chip_select,
	input  wire logic serial_clock,
	input  wire logic serial_data_in,
	input  wire logic program_enable_pin,
	output logic      serial_data_out,
	output logic      serial_data_out_oe,
	output logic      prog_busy,
	output logic      prog_enabled
);
	import sepc_pkg::*;

	localparam int CMD_W  = 3 + AW;
	localparam int FULL_W = CMD_W + DW;
	localparam int CW     = $clog2(FULL_W + 2);

	typedef struct packed {
		sepc_state_e       state_r;
		logic [FULL_W-1:0] shift_r;
		logic [CW-1:0]     cnt_r;
		logic              sk_d_r;
		logic              cs_d_r;
		logic              latch_r;
		logic              dout_r;
		logic              oe_r;
		logic [AW-1:0]     raddr_r;
		logic [4:0]        rbit_r;
		logic [DW-1:0]     rword_r;
		sepc_job_e         job_r;
		logic [AW-1:0]     jaddr_r;
		logic [DW-1:0]     jdata_r;
		logic [1:0]        op_r;
		logic [1:0]        ext_r;
	} sepc_top_s;

	sepc_top_s st_r;
	sepc_top_s st_nxt;

	logic [DW-1:0] mem_r [0:(1<<AW)-1];
	logic [3:0]    pins;
	logic          cs;
	logic          sk;
	logic          di;
	logic          pe;
	logic          tmr_start;
	logic          tmr_busy;
	logic          tmr_done;
	logic          mem_we;
	logic          mem_all;
	logic [AW-1:0] mem_wa;
	logic [DW-1:0] mem_wd;

	////////////////////////////////////////////////////////////////////
	sepc_sync #(
		.W(4)
	) u_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.pin_in  ({chip_select, serial_clock, serial_data_in,
			program_enable_pin}),
		.sync_out(pins)
	);
	assign {cs, sk, di, pe} = pins;

	sepc_timer #(
		.CYCLES(PROG_CYCLES)
	) u_timer (
		.ref_clk(ref_clk),
		.rstn   (rstn),
		.start  (tmr_start),
		.busy   (tmr_busy),
		.done   (tmr_done)
	);

	// Length of command including data, by opcode
	function automatic logic [CW-1:0] cmd_len(input logic [1:0] op,
		input logic [1:0] ext);
		if (op == `SEPC_OP_WRITE ||
			(op == `SEPC_OP_EXT && ext == `SEPC_EXT_WRALL))
			cmd_len = CW'(FULL_W);
		else
			cmd_len = CW'(CMD_W);
	endfunction

	////////////////////////////////////////////////////////////////////
	logic           sk_rise;
	logic           sk_fall;
	logic           cs_fall;
	logic [1:0]     op;
	logic [1:0]     ext;
	logic [CW-1:0]  len;
	logic           armed;

	always_comb begin
		st_nxt    = st_r;
		tmr_start = 1'b0;
		sk_rise   = sk && !st_r.sk_d_r;
		sk_fall   = !sk && st_r.sk_d_r;
		cs_fall   = !cs && st_r.cs_d_r;
		st_nxt.sk_d_r = sk;
		st_nxt.cs_d_r = cs;
		op  = st_r.op_r;
		ext = st_r.ext_r;
		if (st_r.cnt_r >= CW'(CMD_W))
			len = cmd_len(op, ext);
		else
			len = CW'(FULL_W);
		armed = st_r.latch_r && pe;
		case (st_r.state_r)
		SEPC_ST_IDLE: begin
			st_nxt.oe_r = 1'b0;
			if (cs && !tmr_busy && sk_rise && di) begin
				st_nxt.state_r = SEPC_ST_CMD;
				st_nxt.shift_r = FULL_W'(1);
				st_nxt.cnt_r   = CW'(1);
			end else if (cs && tmr_busy) begin
				st_nxt.state_r = SEPC_ST_WAIT;
			end
		end
		SEPC_ST_CMD: begin
			if (cs_fall) begin
				st_nxt.state_r = SEPC_ST_IDLE;
				// Full command only; partial ones fall away
				if (st_r.cnt_r == len && op != `SEPC_OP_READ) begin
					if (op == `SEPC_OP_EXT &&
						ext == `SEPC_EXT_ENABLE)
						st_nxt.latch_r = 1'b1;
					else if (op == `SEPC_OP_EXT &&
						ext == `SEPC_EXT_DISABLE)
						st_nxt.latch_r = 1'b0;
					else if (armed) begin
						tmr_start = 1'b1;
						st_nxt.job_r  = SEPC_JOB_ONE;
						st_nxt.jaddr_r = st_r.shift_r[DW +: AW];
						st_nxt.jdata_r = st_r.shift_r[DW-1:0];
						if (op == `SEPC_OP_ERASE) begin
							st_nxt.jaddr_r = st_r.shift_r[AW-1:0];
							st_nxt.jdata_r = '1;
						end else if (op == `SEPC_OP_EXT) begin
							st_nxt.job_r  = SEPC_JOB_ALL;
							if (ext == `SEPC_EXT_ERALL)
								st_nxt.jdata_r = '1;
						end
					end
				end
			end else if (sk_rise && st_r.cnt_r < len) begin
				st_nxt.shift_r = {st_r.shift_r[FULL_W-2:0], di};
				st_nxt.cnt_r   = st_r.cnt_r + CW'(1);
				// Read opcode complete with address
				if (st_r.cnt_r + CW'(1) == CW'(CMD_W)) begin
					st_nxt.op_r  = st_r.shift_r[CMD_W-3 -: 2];
					st_nxt.ext_r = st_r.shift_r[AW-2 -: 2];
				end
				if (st_r.cnt_r + CW'(1) == CW'(CMD_W) &&
					st_r.shift_r[CMD_W-3 -: 2] == `SEPC_OP_READ) begin
					st_nxt.state_r = SEPC_ST_READ;
					st_nxt.raddr_r = {st_r.shift_r[AW-2:0], di};
					st_nxt.rbit_r  = 5'h00;
					// Dummy zero goes out on the last address rise
					st_nxt.oe_r    = 1'b1;
					st_nxt.dout_r  = 1'b0;
					st_nxt.rword_r = mem_r[{st_r.shift_r[AW-2:0], di}];
				end
			end
		end
		SEPC_ST_READ: begin
			if (!cs) begin
				st_nxt.state_r = SEPC_ST_IDLE;
				st_nxt.oe_r    = 1'b0;
			end else if (sk_rise) begin
				st_nxt.dout_r  = st_r.rword_r[DW-1];
				st_nxt.rword_r = {st_r.rword_r[DW-2:0], 1'b0};
				st_nxt.rbit_r  = st_r.rbit_r + 5'h01;
				if (st_r.rbit_r == 5'(DW - 1)) begin
					st_nxt.rbit_r  = 5'h00;
					st_nxt.raddr_r = st_r.raddr_r + AW'(1);
					st_nxt.rword_r = mem_r[st_r.raddr_r + AW'(1)];
				end
			end
		end
		SEPC_ST_WAIT: begin
			st_nxt.oe_r   = 1'b1;
			st_nxt.dout_r = !tmr_busy;
			if (!cs) begin
				st_nxt.state_r = SEPC_ST_IDLE;
				st_nxt.oe_r    = 1'b0;
			end else if (!tmr_busy && sk_fall && di) begin
				st_nxt.oe_r    = 1'b0;
				st_nxt.state_r = SEPC_ST_IDLE;
			end
		end
		default: st_nxt.state_r = SEPC_ST_IDLE;
		endcase
		// Job lasts from timer start through the timer's done pulse
		if (tmr_done)
			st_nxt.job_r = SEPC_JOB_NONE;
	end

	////////////////////////////////////////////////////////////////////
	// Array update runs off ref_clk, no serial clock needed
	always_comb begin
		mem_we  = 1'b0;
		mem_all = 1'b0;
		mem_wa  = st_r.jaddr_r;
		mem_wd  = st_r.jdata_r;
		if (st_r.job_r == SEPC_JOB_ONE && tmr_done) begin
			mem_we = 1'b1;
		end else if (st_r.job_r == SEPC_JOB_ALL && tmr_done) begin
			mem_all = 1'b1;
		end
	end

	// Whole array lands at once, so a short timer cannot cut a fill
	always_ff @(posedge ref_clk) begin
		if (mem_all) begin
			for (int i = 0; i < (1 << AW); i++)
				mem_r[i] <= mem_wd;
		end else if (mem_we) begin
			mem_r[mem_wa] <= mem_wd;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign serial_data_out    = st_r.dout_r;
	assign serial_data_out_oe = st_r.oe_r;
	assign prog_busy          = tmr_busy;
	assign prog_enabled       = st_r.latch_r;

	////////////////////////////////////////////////////////////////////
	sequence s_busy_polled;
		st_r.state_r == SEPC_ST_WAIT && tmr_busy;
	endsequence

	property p_status_low;
		@(posedge ref_clk) disable iff (!rstn)
		s_busy_polled ##1 tmr_busy |-> serial_data_out == 1'b0;
	endproperty
	a_status_low: assert property (p_status_low)
		else $error("status high while busy");

	property p_status_oe;
		@(posedge ref_clk) disable iff (!rstn)
		s_busy_polled ##1 cs |-> serial_data_out_oe;
	endproperty
	a_status_oe: assert property (p_status_oe)
		else $error("status not driven while polled");

	property p_reset_latch;
		@(posedge ref_clk) $rose(rstn) |-> !prog_enabled;
	endproperty
	a_reset_latch: assert property (p_reset_latch)
		else $error("latch set after reset");

	property p_no_start_off;
		@(posedge ref_clk) disable iff (!rstn)
		tmr_start |-> st_r.latch_r && pe;
	endproperty
	a_no_start_off: assert property (p_no_start_off)
		else $error("program start while disabled");

	property p_cycle_len;
		@(posedge ref_clk) disable iff (!rstn)
		$rose(prog_busy) |-> prog_busy [*8];
	endproperty
	a_cycle_len: assert property (p_cycle_len)
		else $error("timed cycle too short");

	property p_start_on_fall;
		@(posedge ref_clk) disable iff (!rstn)
		tmr_start |-> !cs && st_r.state_r == SEPC_ST_CMD;
	endproperty
	a_start_on_fall: assert property (p_start_on_fall)
		else $error("cycle start without select fall");

	property p_partial_drop;
		@(posedge ref_clk) disable iff (!rstn)
		st_r.state_r == SEPC_ST_CMD && !cs && st_r.cnt_r < CW'(CMD_W)
		|-> !tmr_start;
	endproperty
	a_partial_drop: assert property (p_partial_drop)
		else $error("partial command started cycle");

	property p_latch_hold;
		@(posedge ref_clk) disable iff (!rstn)
		prog_enabled && st_r.state_r != SEPC_ST_CMD |=> prog_enabled;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latch dropped without disable");
endmodule
`default_nettype wire

// file: sim/sepc_host.sv
// Host model driving the three-wire serial bus of sepc_top.
// Assumes ref_clk at 10 MHz; every pin changes on its falling edge.
`timescale 1ns/10ps
`default_nettype none
module sepc_host (
	input  wire logic ref_clk,
	input  wire logic do_pin,
	output logic      chip_select,
	output logic      serial_clock,
	output logic      serial_data_in
);
	initial begin
		chip_select = 1'h0;
		serial_clock = 1'h0;
		serial_data_in = 1'h0;
	end
	////////////////////////////////////////////////////////////////////
	// Four ref_clk per phase; output sampled just before the rise
	task automatic bit_io(input logic b, output logic o);
		@(negedge ref_clk);
		serial_data_in = b;
		repeat (3) @(negedge ref_clk);
		o = do_pin;
		serial_clock = 1'h1;
		repeat (4) @(negedge ref_clk);
		serial_clock = 1'h0;
	endtask
	task automatic select();
		@(negedge ref_clk);
		chip_select = 1'h1;
		repeat (4) @(negedge ref_clk);
	endtask
	// Low past the minimum low time; data line no longer meaningful
	task automatic deselect();
		@(negedge ref_clk);
		chip_select = 1'h0;
		serial_data_in = ~serial_data_in;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic shift(input logic [28:0] v, input int n);
		logic o;
		for (int i = 28; i > 28 - n; i--) begin
			bit_io(v[i], o);
		end
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic cmd13(input logic [12:0] v);
		select();
		shift({v, 16'h0000}, 13);
		deselect();
	endtask
	task automatic cmd29(input logic [28:0] v);
		select();
		shift(v, 29);
		deselect();
	endtask
	// Dummy bit then 16 data bits
	task automatic read(input logic [9:0] a, output logic [16:0] d);
		logic o;
		select();
		shift({3'h6, a, 16'h0000}, 13);
		for (int i = 16; i >= 0; i--) begin
			bit_io(1'h0, o);
			d[i] = o;
		end
		deselect();
	endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for sepc_top with a host bus model.
// Assumes a pull-up on the serial output pin while it is released.
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int PC = 16;
	logic ref_clk, rstn, program_enable_pin, saw_busy;
	logic serial_data_out, serial_data_out_oe, prog_busy, prog_enabled;
	logic chip_select, serial_clock, serial_data_in;
	wire logic do_pin;
	int n_errors, tests_run, run_len, last_len;
	initial ref_clk = 1'h0;
	always #50 ref_clk = ~ref_clk;
	assign do_pin = serial_data_out_oe ? serial_data_out : 1'h1;
	sepc_top #(.PROG_CYCLES(PC)) dut_u (
		.ref_clk(ref_clk), .rstn(rstn), .chip_select(chip_select),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in),
		.program_enable_pin(program_enable_pin),
		.serial_data_out(serial_data_out),
		.serial_data_out_oe(serial_data_out_oe),
		.prog_busy(prog_busy), .prog_enabled(prog_enabled));
	sepc_host host_u (
		.ref_clk(ref_clk), .do_pin(do_pin), .chip_select(chip_select),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in));
	////////////////////////////////////////////////////////////////////
	// Length of the last busy run
	always @(posedge ref_clk) begin
		if (prog_busy === 1'h1) begin
			run_len <= run_len + 1;
			saw_busy <= 1'h1;
		end else if (run_len != 0) begin
			last_len <= run_len;
			run_len <= 0;
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk_bit(input string s, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_word(input string s, input logic [16:0] e,
			input logic [16:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	// Wait out a timed cycle if one is expected, then judge it
	task automatic settle(input logic e);
		int i;
		i = 0;
		while (i < 300 && (i < 12 || prog_busy !== 1'h0 ||
				(e && saw_busy !== 1'h1))) begin
			@(negedge ref_clk);
			i++;
		end
		if (i == 300) begin
			n_errors++;
			$display("wrong value busy wait expected idle seen busy");
			tally_and_finish();
		end else begin
			// Run length is latched one edge after busy drops
			repeat (2) @(negedge ref_clk);
			chk_bit("busy seen", e, saw_busy);
			if (e) chk_word("busy length", 17'h0_0010, last_len[16:0]);
			saw_busy = 1'h0;
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		logic [16:0] d;
		rstn = 1'h0;
		program_enable_pin = 1'h1;
		saw_busy = 1'h0;
		run_len = 0;
		last_len = 0;
		repeat (16) @(negedge ref_clk);
		rstn = 1'h1;
		repeat (3) @(negedge ref_clk);
		chk_bit("latch at reset", 1'h0, prog_enabled);
		host_u.cmd29({3'h5, 10'h003, 16'h1234});
		settle(1'h0);
		host_u.read(10'h003, d);
		chk_bit("read dummy", 1'h0, d[16]);
		$display("test locked done");
		host_u.cmd13({3'h4, 2'h3, 8'h00});
		settle(1'h0);
		chk_bit("latch set", 1'h1, prog_enabled);
		host_u.cmd13({3'h4, 2'h2, 8'h00});
		settle(1'h1);
		host_u.read(10'h005, d);
		chk_word("erase all", 17'h0_ffff, d);
		host_u.cmd29({3'h4, 2'h1, 8'h00, 16'ha5a5});
		settle(1'h1);
		host_u.read(10'h3ff, d);
		chk_word("write all", 17'h0_a5a5, d);
		$display("test all done");
		host_u.cmd29({3'h5, 10'h003, 16'h1234});
		host_u.select();
		chk_bit("status drive", 1'h1, serial_data_out_oe);
		chk_bit("status busy", 1'h0, serial_data_out);
		settle(1'h1);
		repeat (2) @(negedge ref_clk);
		chk_bit("status ready", 1'h1, serial_data_out);
		host_u.deselect();
		host_u.read(10'h003, d);
		chk_word("word write", 17'h0_1234, d);
		host_u.cmd13({3'h7, 10'h003});
		settle(1'h1);
		host_u.read(10'h003, d);
		chk_word("erased word", 17'h0_ffff, d);
		host_u.read(10'h004, d);
		chk_word("neighbour", 17'h0_a5a5, d);
		$display("test word done");
		program_enable_pin = 1'h0;
		host_u.cmd29({3'h5, 10'h004, 16'h0f0f});
		settle(1'h0);
		host_u.cmd13({3'h4, 2'h2, 8'h00});
		settle(1'h0);
		program_enable_pin = 1'h1;
		host_u.cmd13({3'h5, 10'h004});
		settle(1'h0);
		host_u.read(10'h004, d);
		chk_word("pin low", 17'h0_a5a5, d);
		$display("test refuse done");
		host_u.cmd13({3'h4, 2'h0, 8'h00});
		settle(1'h0);
		chk_bit("latch clear", 1'h0, prog_enabled);
		host_u.cmd13({3'h7, 10'h004});
		settle(1'h0);
		host_u.cmd29({3'h4, 2'h1, 8'h00, 16'h0000});
		settle(1'h0);
		host_u.read(10'h004, d);
		chk_word("locked word", 17'h0_a5a5, d);
		$display("test disable done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
